// ==== logic/rfs_pkg.sv ====
/*
  rfs_pkg: register map, field positions, reset values and encodings for the
  rf_link_status / reader demodulation configuration register bank.
  Assumes a 32-bit AXI4-Lite register bus; printed offsets are word indices.
*/
package rfs_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  CFG_INDEX      = 8'h1c;
  localparam logic [7:0]  STATUS_INDEX   = 8'h1d;
  localparam logic [9:0]  CFG_ADDR       = {CFG_INDEX, 2'b00};
  localparam logic [9:0]  STATUS_ADDR    = {STATUS_INDEX, 2'b00};

  // configuration word fields
  localparam int          CFG_COLL_LSB   = 5;
  localparam int          CFG_PREFILT    = 4;
  localparam int          CFG_RECT       = 3;
  localparam int          CFG_SYNC       = 2;
  localparam int          CFG_FSK        = 1;
  localparam int          CFG_BPSK       = 0;

  // status word fields
  localparam int          ST_STATE_LSB   = 24;
  localparam int          ST_GEAR_LSB    = 20;
  localparam int          ST_PLL         = 19;
  localparam int          ST_CRC         = 18;
  localparam int          ST_OWN_FIELD   = 17;
  localparam int          ST_EXT_FIELD   = 16;
  localparam int          ST_FAIL_LSB    = 13;
  localparam int          ST_RX_EN       = 12;
  localparam int          ST_TX_ACT      = 11;
  localparam int          ST_RX_ACT      = 10;
  localparam int          ST_GAIN_LSB    = 0;

  // reset values
  localparam logic [1:0]  COLL_RST       = 2'h0;
  localparam logic        PREFILT_RST    = 1'h0;
  localparam logic        RECT_RST       = 1'h0;
  localparam logic        SYNC_RST       = 1'h0;
  localparam logic        BPSK_RST       = 1'h0;
  localparam logic [2:0]  FAIL_RST       = 3'h0;

  localparam logic [1:0]  COLL_DISABLED  = 2'h3;
  localparam logic [1:0]  AVG_LAST       = 2'h3;

  // axi responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // transceive sequencer states as reported
  typedef enum logic [2:0] {
    TRX_IDLE      = 3'h0,
    TRX_WAIT_TX   = 3'h1,
    TRX_TX        = 3'h2,
    TRX_WAIT_RX   = 3'h3,
    TRX_WAIT_DATA = 3'h4,
    TRX_RX        = 3'h5,
    TRX_LOOPBACK  = 3'h6
  } rfs_trx_t;

  // active-mode failure causes
  typedef enum logic [2:0] {
    FAIL_NONE      = 3'h0,
    FAIL_EXT_INIT  = 3'h1,
    FAIL_EXT_ACT   = 3'h2,
    FAIL_NO_EXT    = 3'h3,
    FAIL_PEER_DROP = 3'h4
  } rfs_fail_t;

endpackage

// ==== logic/rfs_status_config.sv ====
/*
  rfs_status_config: AXI4-Lite register bank holding the reader demodulation
  configuration word (which steers a small sample pre-processing path) and the
  read-only rf_link_status word assembled from live transceiver state.
  Assumes all status inputs are synchronous to aclk.
*/
`timescale 1ns/10ps
module rfs_status_config #(
  parameter int              SAMPLE_W    = 8,
  parameter int              FILT_CYCLES = 4,
  parameter logic [15:0]     CRC_RESIDUE = 16'h0000
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite slave
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // live transceiver state
  input  wire logic [2:0]           trx_state,
  input  wire logic [3:0]           power_ctrl_step,
  input  wire logic                 rf_on,
  input  wire logic                 rf_freq_ok,
  input  wire logic                 pll_locked,
  input  wire logic [15:0]          crc_value,
  input  wire logic                 crc_inverted,
  input  wire logic                 own_field_on,
  input  wire logic                 level_detect,
  input  wire logic                 fail_event,
  input  wire logic [2:0]           fail_code,
  input  wire logic                 field_drive_on,
  input  wire logic                 decoder_ready,
  input  wire logic                 encoder_busy,
  input  wire logic                 decoder_busy,
  input  wire logic                 fsk_mode,
  input  wire logic [9:0]           gain_level,
  // sample path
  input  wire logic                 adc_valid,
  input  wire logic [SAMPLE_W-1:0]  adc_data,
  output logic                      sample_valid,
  output logic [SAMPLE_W-1:0]       sample_out,
  // configuration to the demodulator
  output logic [1:0]                collision_threshold,
  output logic                      collision_detect_en,
  output logic                      sync_at_max,
  output logic                      bpsk_select,
  output logic                      external_field_seen
);

  localparam int FCW = $clog2(FILT_CYCLES + 1);

  typedef struct packed {
    logic                 awready;
    logic                 aw_full;
    logic [11:0]          awaddr;
    logic                 wready;
    logic                 w_full;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [1:0]           coll;
    logic                 coll_en;
    logic                 prefilt;
    logic                 rect;
    logic                 sync;
    logic                 bpsk;
    logic [2:0]           fail;
    logic                 drive_q;
    logic                 ext_field;
    logic [FCW-1:0]       filt_cnt;
    logic [1:0]           avg_cnt;
    logic [SAMPLE_W+1:0]  avg_acc;
    logic                 smp_valid;
    logic [SAMPLE_W-1:0]  smp;
  } rfs_state_t;

  rfs_state_t s;
  rfs_state_t next_s;

  // word address decode shared by the read and write paths
  function automatic logic [1:0] rfs_decode(input logic [11:0] addr);
    if (addr[11:2] == rfs_pkg::CFG_ADDR[9:2]) begin
      rfs_decode = 2'h1;
    end else if (addr[11:2] == rfs_pkg::STATUS_ADDR[9:2]) begin
      rfs_decode = 2'h2;
    end else begin
      rfs_decode = 2'h0;
    end
  endfunction

  // crc comparison against zero or the residue
  function automatic logic rfs_crc_good(input logic [15:0] crc, input logic inv);
    rfs_crc_good = (crc == (inv ? CRC_RESIDUE : 16'h0000));
  endfunction

  logic [SAMPLE_W-1:0] shaped;
  logic [31:0]         status_word;
  logic [31:0]         cfg_word;
  logic [1:0]          wsel;
  logic [1:0]          rsel;

  always_comb begin
    next_s = s;

    // status is assembled from live inputs at read time; only the failure cause and filtered field flag are latched
    status_word = 32'h0000_0000;
    status_word[rfs_pkg::ST_STATE_LSB +: 3] = trx_state;
    status_word[rfs_pkg::ST_GEAR_LSB +: 4]  = power_ctrl_step;
    status_word[rfs_pkg::ST_PLL]            = rf_on & rf_freq_ok & pll_locked;
    status_word[rfs_pkg::ST_CRC]            = rfs_crc_good(crc_value, crc_inverted);
    status_word[rfs_pkg::ST_OWN_FIELD]      = own_field_on;
    status_word[rfs_pkg::ST_EXT_FIELD]      = s.ext_field;
    status_word[rfs_pkg::ST_FAIL_LSB +: 3]  = s.fail;
    status_word[rfs_pkg::ST_RX_EN]          = decoder_ready;
    status_word[rfs_pkg::ST_TX_ACT]         = encoder_busy;
    status_word[rfs_pkg::ST_RX_ACT]         = decoder_busy;
    status_word[rfs_pkg::ST_GAIN_LSB +: 10] = gain_level;

    cfg_word = 32'h0000_0000;
    cfg_word[rfs_pkg::CFG_COLL_LSB +: 2] = s.coll;
    cfg_word[rfs_pkg::CFG_PREFILT]       = s.prefilt;
    cfg_word[rfs_pkg::CFG_RECT]          = s.rect;
    cfg_word[rfs_pkg::CFG_SYNC]          = s.sync;
    cfg_word[rfs_pkg::CFG_FSK]           = fsk_mode;
    cfg_word[rfs_pkg::CFG_BPSK]          = s.bpsk;

    // write channel: address and data are caught independently
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    wsel = rfs_decode(s.awaddr);
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = (wsel == 2'h0) ? rfs_pkg::RESP_SLVERR : rfs_pkg::RESP_OKAY;
      // only the low byte holds writable bits; the status word takes no write
      if (wsel == 2'h1 && s.wstrb[0]) begin
        next_s.coll    = s.wdata[rfs_pkg::CFG_COLL_LSB +: 2];
        next_s.prefilt = s.wdata[rfs_pkg::CFG_PREFILT];
        next_s.rect    = s.wdata[rfs_pkg::CFG_RECT];
        next_s.sync    = s.wdata[rfs_pkg::CFG_SYNC];
        next_s.bpsk    = s.wdata[rfs_pkg::CFG_BPSK];
      end
    end
    // one write in flight: no new address or data until the response leaves
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;
    next_s.coll_en = (next_s.coll != rfs_pkg::COLL_DISABLED);

    // read channel: answer one cycle after the address is taken
    rsel = rfs_decode(s_axi_araddr);
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      if (rsel == 2'h1) begin
        next_s.rdata = cfg_word;
        next_s.rresp = rfs_pkg::RESP_OKAY;
      end else if (rsel == 2'h2) begin
        next_s.rdata = status_word;
        next_s.rresp = rfs_pkg::RESP_OKAY;
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = rfs_pkg::RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;

    // failure cause: cleared on the rising edge of the drive enable, a new
    // failure in the same cycle wins so it is never lost
    next_s.drive_q = field_drive_on;
    if (field_drive_on && !s.drive_q) begin
      next_s.fail = rfs_pkg::FAIL_RST;
    end
    if (fail_event) begin
      next_s.fail = fail_code;
    end

    // level detector filter: a change must persist FILT_CYCLES cycles,
    // which trades a little latency for immunity to detector glitches
    if (level_detect == s.ext_field) begin
      next_s.filt_cnt = '0;
    end else if (s.filt_cnt == FCW'(FILT_CYCLES - 1)) begin
      next_s.filt_cnt  = '0;
      next_s.ext_field = level_detect;
    end else begin
      next_s.filt_cnt = s.filt_cnt + FCW'(1);
    end

    // sample path: optional squaring about mid-scale, then optional average
    if (s.rect) begin
      shaped = adc_data[SAMPLE_W-1] ? {SAMPLE_W{1'b1}} : {SAMPLE_W{1'b0}};
    end else begin
      shaped = adc_data;
    end
    next_s.smp_valid = 1'b0;
    if (adc_valid) begin
      if (s.prefilt) begin
        if (s.avg_cnt == rfs_pkg::AVG_LAST) begin
          next_s.smp       = SAMPLE_W'((s.avg_acc + (SAMPLE_W+2)'(shaped)) >> 2);
          next_s.smp_valid = 1'b1;
          next_s.avg_acc   = '0;
          next_s.avg_cnt   = 2'h0;
        end else begin
          next_s.avg_acc = s.avg_acc + (SAMPLE_W+2)'(shaped);
          next_s.avg_cnt = s.avg_cnt + 2'h1;
        end
      end else begin
        next_s.smp       = shaped;
        next_s.smp_valid = 1'b1;
        next_s.avg_acc   = '0;
        next_s.avg_cnt   = 2'h0;
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.coll    <= rfs_pkg::COLL_RST;
      s.coll_en <= 1'b1;
      s.prefilt <= rfs_pkg::PREFILT_RST;
      s.rect    <= rfs_pkg::RECT_RST;
      s.sync    <= rfs_pkg::SYNC_RST;
      s.bpsk    <= rfs_pkg::BPSK_RST;
      s.fail    <= rfs_pkg::FAIL_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready       = s.awready;
  assign s_axi_wready        = s.wready;
  assign s_axi_bvalid        = s.bvalid;
  assign s_axi_bresp         = s.bresp;
  assign s_axi_arready       = s.arready;
  assign s_axi_rvalid        = s.rvalid;
  assign s_axi_rdata         = s.rdata;
  assign s_axi_rresp         = s.rresp;
  assign sample_valid        = s.smp_valid;
  assign sample_out          = s.smp;
  assign collision_threshold = s.coll;
  assign collision_detect_en = s.coll_en;
  assign sync_at_max         = s.sync;
  assign bpsk_select         = s.bpsk;
  assign external_field_seen = s.ext_field;

  // checks on the register bank and sample path
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_COLL_OFF: assert property (collision_detect_en == (collision_threshold != 2'h3))
    else $error("collision detect enable disagrees with threshold code");
  AST_AVG_FOURTH: assert property (
    s.prefilt && adc_valid && s.avg_cnt != 2'h3 |=> !sample_valid)
    else $error("averaged sample issued before four inputs");
  AST_AVG_OUT: assert property (s.prefilt && adc_valid && s.avg_cnt == 2'h3 |=> sample_valid)
    else $error("averaged sample missing after fourth input");
  AST_RECT: assert property (
    s.rect && !s.prefilt && adc_valid |=> sample_out == '0 || sample_out == '1)
    else $error("shaped sample not rectangular");
  AST_BPSK_WR: assert property (
    s.aw_full && s.w_full && !s.bvalid && rfs_decode(s.awaddr) == 2'h1 && s.wstrb[0]
    |=> bpsk_select == $past(s.wdata[0]) && s_axi_bvalid)
    else $error("configuration write not applied");
  AST_FAIL_SET: assert property (fail_event |=> s.fail == $past(fail_code))
    else $error("failure cause not captured");
  AST_FAIL_CLR: assert property (
    field_drive_on && !s.drive_q && !fail_event |=> s.fail == 3'h0)
    else $error("failure cause not cleared by drive enable");
  AST_GAIN_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h2
    |=> s_axi_rvalid && s_axi_rdata[9:0] == $past(gain_level) && s_axi_rdata[31:27] == 5'h00)
    else $error("status read does not show live gain level");
  AST_PLL_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h2
    |=> s_axi_rdata[19] == ($past(rf_on) && $past(rf_freq_ok) && $past(pll_locked)))
    else $error("phase loop bit wrong");
  // the filtered flag may only move to the raw level once the full run has been seen
  AST_EXT_FILT: assert property (
    $changed(external_field_seen)
    |-> external_field_seen == $past(level_detect) && $past(s.filt_cnt) == FCW'(FILT_CYCLES - 1))
    else $error("external field flag moved before the detector settled");

  // configuration read-back: the frequency-shift bit is live, the unused top reads zero
  AST_FSK_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h1
    |=> s_axi_rdata[1] == $past(fsk_mode) && s_axi_rdata[31:7] == 25'h0)
    else $error("configuration read shows a stale scheme bit");

  // status read-back: each field is the value present at the address edge
  AST_STATE_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h2
    |=> s_axi_rdata[26:24] == $past(trx_state))
    else $error("sequencer state not shown live");
  AST_GEAR_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h2
    |=> s_axi_rdata[23:20] == $past(power_ctrl_step))
    else $error("power step not shown live");
  AST_CRC_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h2
    |=> s_axi_rdata[18] == ($past(crc_value) == ($past(crc_inverted) ? CRC_RESIDUE : 16'h0000)))
    else $error("crc good bit wrong");
  AST_ENC_READ: assert property (
    s_axi_arvalid && s_axi_arready && rfs_decode(s_axi_araddr) == 2'h2
    |=> s_axi_rdata[11] == $past(encoder_busy))
    else $error("encoder activity bit wrong");

  // a read answer must stand untouched until the master takes it
  AST_RD_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before it was taken");

  // a write aimed at the status word must leave every configuration field alone
  AST_STS_NO_WR: assert property (
    s.aw_full && s.w_full && !s.bvalid && rfs_decode(s.awaddr) == 2'h2
    |=> $stable(collision_threshold) && $stable(sync_at_max) && $stable(bpsk_select)
        && $stable(s.prefilt) && $stable(s.rect))
    else $error("status write disturbed the configuration");

  COV_CFG_WRITE: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
  COV_STATUS_READ: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
  COV_AVG: cover property (s.prefilt && sample_valid);
  COV_FAIL_CLR: cover property (s.fail != 3'h0 ##1 s.fail == 3'h0);
  COV_EXT_FIELD: cover property ($rose(external_field_seen));

endmodule

// ==== tb/rfs_status_config_tb.sv ====
/*
  rfs_status_config_tb: self-checking bench for the rf_link_status / demodulation
  configuration register bank, driven over AXI4-Lite with a small bench model.
  Assumes one 50 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module rfs_status_config_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, fail_event, field_drive_on;
  logic        rf_on, rf_freq_ok, pll_locked, crc_inverted, own_field_on, level_detect;
  logic        decoder_ready, encoder_busy, decoder_busy, fsk_mode, adc_valid;
  logic        sample_valid, sync_at_max, bpsk_select, ext_seen, coll_en, ext_m;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, got, cfg_m, wv;
  logic [3:0]  wstrb, step;
  logic [1:0]  bresp, rresp, resp, coll_thr;
  logic [2:0]  trx_state, fail_code, fail_m;
  logic [15:0] crc_value;
  logic [9:0]  gain_level;
  logic [7:0]  adc_data, sample_out, d;
  logic [7:0]  smp_q[$];
  int          miscompares, samples_checked, sum;
  localparam logic [11:0] CFG = {2'h0, rfs_pkg::CFG_ADDR};
  localparam logic [11:0] STS = {2'h0, rfs_pkg::STATUS_ADDR};
  // arbitrary non-zero residue so the inverted-crc case can be told apart
  localparam logic [15:0] CRC_RES = 16'h5a5a;

  // filter shortened to two cycles to keep the run brief
  rfs_status_config #(.SAMPLE_W(8), .FILT_CYCLES(2), .CRC_RESIDUE(CRC_RES)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trx_state(trx_state),
    .power_ctrl_step(step), .rf_on(rf_on), .rf_freq_ok(rf_freq_ok), .pll_locked(pll_locked),
    .crc_value(crc_value), .crc_inverted(crc_inverted), .own_field_on(own_field_on),
    .level_detect(level_detect), .fail_event(fail_event), .fail_code(fail_code),
    .field_drive_on(field_drive_on), .decoder_ready(decoder_ready), .encoder_busy(encoder_busy),
    .decoder_busy(decoder_busy), .fsk_mode(fsk_mode), .gain_level(gain_level),
    .adc_valid(adc_valid), .adc_data(adc_data), .sample_valid(sample_valid), .sample_out(sample_out),
    .collision_threshold(coll_thr), .collision_detect_en(coll_en), .sync_at_max(sync_at_max),
    .bpsk_select(bpsk_select), .external_field_seen(ext_seen));

  always #10 aclk = ~aclk;

  // 32-bit fibonacci shift register, taps 32 22 2 1
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a hang counts as a mismatch and closes the run
  task automatic guard(input int n);
    if (n > 1000) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  endtask

  // ready is registered, so sampling it before the edge shows what the edge will see
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
    int n;
    logic aok, wok, sa, sw;
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    aok = 0; wok = 0; n = 0;
    while (!(aok && wok)) begin
      @(negedge aclk); sa = awready && awvalid; sw = wready && wvalid;
      @(posedge aclk); n++; guard(n);
      if (sa) begin aok = 1; awvalid <= 1'b0; end
      if (sw) begin wok = 1; wvalid <= 1'b0; end
    end
    do begin
      @(negedge aclk); sa = bvalid; r = bresp;
      @(posedge aclk); n++; guard(n);
    end while (!sa);
    bready <= 1'b0;
    // one spare edge, so a following call never re-raises bready in the same step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    logic sa;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; n = 0;
    do begin
      @(negedge aclk); sa = arready;
      @(posedge aclk); n++; guard(n);
    end while (!sa);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk); sa = rvalid; v = rdata; r = rresp;
      @(posedge aclk); n++; guard(n);
    end while (!sa);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // status word model built from the live inputs
  task automatic chk_status;
    axi_rd(STS, got, resp);
    chk(got, {5'h0, trx_state, step, rf_on & rf_freq_ok & pll_locked,
              crc_value == (crc_inverted ? CRC_RES : 16'h0000), own_field_on,
              ext_m, fail_m, decoder_ready, encoder_busy, decoder_busy, gain_level});
    chk(resp, rfs_pkg::RESP_OKAY);
  endtask

  task automatic send(input logic [7:0] x, input logic ev, input logic [7:0] ex);
    adc_valid <= 1'b1; adc_data <= x;
    @(posedge aclk); adc_valid <= 1'b0;
    @(negedge aclk);
    chk(sample_valid, ev);
    if (ev) chk(sample_out, ex);
    @(posedge aclk);
  endtask

  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; trx_state = 0; step = 0; rf_on = 0;
    rf_freq_ok = 0; pll_locked = 0; crc_value = 0; crc_inverted = 0; own_field_on = 0;
    level_detect = 0; fail_event = 0; fail_code = 0; field_drive_on = 0; decoder_ready = 0;
    encoder_busy = 0; decoder_busy = 0; fsk_mode = 1; gain_level = 0; adc_valid = 0; adc_data = 0;
    miscompares = 0; samples_checked = 0; rnd = 32'd84940; fail_m = 0; ext_m = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk); chk(coll_en, 1'b1);
    @(posedge aclk);
    axi_rd(CFG, got, resp);
    chk(got, 32'h2);
    chk_status();
    // every collision code, with rect, sync and bpsk varied alongside and prefilt held at zero
    for (int c = 0; c < 4; c++) begin
      wv = {25'h0, c[1:0], 1'b0, c[0], c[1], 1'b1, ~c[0]};
      axi_wr(CFG, wv, 4'hf, resp);
      chk(resp, rfs_pkg::RESP_OKAY);
      cfg_m = wv & 32'h7d;
      axi_rd(CFG, got, resp);
      chk(got, cfg_m | {fsk_mode, 1'b0});
      chk(coll_thr, c[1:0]);
      chk(coll_en, c != 3);
      chk(sync_at_max, cfg_m[2]);
      chk(bpsk_select, cfg_m[0]);
      fsk_mode <= c[0];
    end
    axi_wr(CFG, 32'h0, 4'he, resp);
    axi_rd(CFG, got, resp);
    chk(got, cfg_m | {fsk_mode, 1'b0});
    axi_wr(STS, 32'hffffffff, 4'hf, resp);
    chk(resp, rfs_pkg::RESP_OKAY);
    axi_rd(12'h100, got, resp);
    chk(got, 32'h0);
    chk(resp, rfs_pkg::RESP_SLVERR);
    axi_wr(12'h100, 32'h1, 4'hf, resp);
    chk(resp, rfs_pkg::RESP_SLVERR);
    // live status fields with random values, gain at both ends
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      trx_state <= 3'(i % 7); step <= rnd[3:0]; rf_on <= rnd[4] | i[0]; rf_freq_ok <= rnd[5] | i[0];
      pll_locked <= rnd[6] | i[0]; crc_inverted <= rnd[8];
      crc_value <= rnd[7] ? (rnd[13] ? CRC_RES : 16'h0000) : {rnd[31:17], 1'b1};
      own_field_on <= rnd[9]; decoder_ready <= rnd[10]; encoder_busy <= rnd[11]; decoder_busy <= rnd[12];
      gain_level <= (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : rnd[25:16];
      @(posedge aclk);
      chk_status();
    end
    // each failure cause, then cleared by raising the field drive
    for (int c = 1; c < 5; c++) begin
      fail_event <= 1'b1; fail_code <= 3'(c);
      @(posedge aclk); fail_event <= 1'b0; fail_m = 3'(c);
      @(posedge aclk);
      chk_status();
    end
    field_drive_on <= 1'b1;
    repeat (2) @(posedge aclk);
    fail_m = 3'h0;
    chk_status();
    field_drive_on <= 1'b0;
    // a one-cycle detector glitch must be filtered out
    level_detect <= 1'b1;
    @(posedge aclk); level_detect <= 1'b0;
    @(negedge aclk); chk(ext_seen, 1'b0);
    @(negedge aclk); chk(ext_seen, 1'b0);
    // a lasting change is taken on its second edge with the two-cycle filter
    @(posedge aclk); level_detect <= 1'b1;
    repeat (2) @(negedge aclk);
    chk(ext_seen, 1'b0);
    @(negedge aclk); chk(ext_seen, 1'b1);
    @(posedge aclk); ext_m = 1'b1;
    chk_status();
    // sample path: plain, shaped, then averaged in fours
    axi_wr(CFG, 32'h0, 4'hf, resp);
    rnd = lfsr(rnd); d = rnd[7:0];
    send(d, 1'b1, d);
    axi_wr(CFG, 32'h8, 4'hf, resp);
    send(d | 8'h80, 1'b1, 8'hff);
    send(d & 8'h7f, 1'b1, 8'h00);
    axi_wr(CFG, 32'h10, 4'hf, resp);
    // the model keeps the group of samples in a queue and averages it
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd); smp_q.push_back(rnd[7:0]); sum = 0;
      foreach (smp_q[j]) sum += smp_q[j];
      send(rnd[7:0], k == 3, 8'(sum >> 2));
    end
    wrap_up();
  end
endmodule
